//--- rtl/rtcs_serial_port.sv
// The register addresses and the AHB-Lite register port were left to the implementer.
`timescale 1ns/10ps
// Overview of operation
// - status command selector 0 picks first, 1 picks second status register.
// - interrupt command selector 0 picks first, 1 picks second interrupt register.
// - interrupt register access follows current second status register contents.
// - alarm mode gives three bytes; frequency or other modes give one byte.
// - abandoned transfer state is held until explicitly recovered.
// - an accepted stop returns the serial logic to idle.
// - stop is ignored while the device pulls data low.
// - start is not seen while the device pulls data low.
// - during recovery clocking the pending output completes and data is released.
// - after start take code and command; bit 1 reads, bit 0 writes.
// - each received byte within the register's length, and a command byte with the own code, is acknowledged low during the ninth clock.
// - read bytes are shifted out top bit first.
module rtcs_serial_port #(
   parameter logic [3:0] DEV_CODE = `RTCS_DEV_CODE_RESET
) (
   // system
   input wire logic clock,
   input wire logic resetn,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // serial pins, data is open drain
   input wire logic sclPin,
   input wire logic sdaPin,
   output logic sdaOut,
   output logic sdaOe
);
   import rtcs_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   rtcs_core_type q;
   rtcs_core_type d;
   logic sclHigh;
   logic sdaLvl;
   logic sclRise;
   logic sclFall;
   logic sdaRise;
   logic sdaFall;
   logic startSeen;
   logic stopSeen;
   logic [4:0] curAddr;
   logic [2:0] curLen;
   logic accept;

   rtcs_pin_sync u_sync (
      .clock(clock),
      .resetn(resetn),
      .sclPin(sclPin),
      .sdaPin(sdaPin),
      .sclHigh(sclHigh),
      .sdaLvl(sdaLvl),
      .sclRise(sclRise),
      .sclFall(sclFall),
      .sdaRise(sdaRise),
      .sdaFall(sdaFall)
   );

   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [4:0] regBase(input logic [2:0] c);
      logic [4:0] b;
      b = `RTCS_BASE_FREE;
      unique case (c)
         `RTCS_CMD_STATUS1, `RTCS_CMD_STATUS2: b = `RTCS_BASE_STATUS + {4'h0, c[0]};
         `RTCS_CMD_INTA: b = `RTCS_BASE_INTA;
         `RTCS_CMD_INTB: b = `RTCS_BASE_INTB;
         `RTCS_CMD_RT1: b = `RTCS_BASE_RT1;
         `RTCS_CMD_RT2: b = `RTCS_BASE_RT2;
         `RTCS_CMD_CORR: b = `RTCS_BASE_CORR;
         `RTCS_CMD_FREE: b = `RTCS_BASE_FREE;
      endcase
      return b;
   endfunction

   function automatic logic [2:0] regLen(input logic [2:0] c, input logic [7:0] s2);
      logic [2:0] l;
      l = `RTCS_LEN_ONE;
      if (c == `RTCS_CMD_RT1) begin
         l = `RTCS_LEN_RT1;
      end else if (c == `RTCS_CMD_RT2) begin
         l = `RTCS_LEN_RT2;
      end else if (c == `RTCS_CMD_INTA && s2[`RTCS_S2_INTA_ALARM_BIT]) begin
         l = `RTCS_LEN_ALARM;
      end else if (c == `RTCS_CMD_INTB && s2[`RTCS_S2_INTB_ALARM_BIT]) begin
         l = `RTCS_LEN_ALARM;
      end
      return l;
   endfunction

   // byte index of a data word, bit 5 set when the address misses the array
   function automatic logic [5:0] dataIdx(input logic [7:0] a);
      logic [7:0] off;
      off = a - `RTCS_OFS_DATA;
      if (a < `RTCS_OFS_DATA || off[7:2] >= `RTCS_MEM_COUNT) begin
         return 6'h20;
      end
      return off[7:2];
   endfunction

   function automatic logic [31:0] readMux(input rtcs_core_type s, input logic [7:0] a);
      logic [31:0] r;
      logic [5:0] i;
      r = 32'h0;
      i = dataIdx(a);
      if (a == `RTCS_OFS_CTRL) begin
         r[`RTCS_CTRL_EN_BIT] = s.enable;
      end else if (a == `RTCS_OFS_STATUS) begin
         r[`RTCS_STAT_STATE_LSB +: 3] = s.st;
         r[`RTCS_STAT_LOW_BIT] = s.sdaLow;
         r[`RTCS_STAT_CMD_LSB +: 3] = s.cmd;
         r[`RTCS_STAT_RW_BIT] = s.rw;
         r[`RTCS_STAT_IDX_LSB +: 3] = s.byteIdx;
         r[`RTCS_STAT_BUSY_BIT] = (s.st != ST_IDLE);
      end else if (!i[5]) begin
         r[7:0] = s.mem[i[4:0]];
      end
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   assign startSeen = sclHigh & sdaFall;
   assign stopSeen = sclHigh & sdaRise;
   assign curAddr = regBase(q.cmd) + {2'h0, q.byteIdx};
   assign curLen = regLen(q.cmd, q.mem[`RTCS_BASE_STATUS2]);
   assign accept = hsel & hready & htrans[1] & (hsize == 3'h2);

   always_comb begin
      logic [5:0] wi;
      logic [7:0] nb;
      wi = dataIdx(q.apAddr);
      nb = q.mem[curAddr + 5'h1];
      d = q;
      // bus write in its data phase; a serial write in the same cycle wins
      if (q.apWrite) begin
         if (q.apAddr == `RTCS_OFS_CTRL) begin
            d.enable = hwdata[`RTCS_CTRL_EN_BIT];
         end else if (!wi[5]) begin
            d.mem[wi[4:0]] = hwdata[7:0];
         end
      end
      // no timeout anywhere: a stalled transfer stays put
      unique case (q.st)
         ST_IDLE, ST_IGNORE: begin
         end
         ST_GETCMD: begin
            if (sclRise) begin
               d.shift = {q.shift[6:0], sdaLvl};
               d.bitCnt = q.bitCnt + 4'h1;
            end else if (sclFall && q.bitCnt == `RTCS_BYTE_BITS) begin
               if (q.shift[7:4] == DEV_CODE) begin
                  d.st = ST_ACKCMD;
                  d.sdaLow = 1'b1;
                  d.cmd = q.shift[3:1];
                  d.rw = q.shift[0];
                  d.byteIdx = 3'h0;
               end else begin
                  d.st = ST_IGNORE;
               end
            end
         end
         ST_ACKCMD: begin
            if (sclFall) begin
               d.bitCnt = 4'h0;
               if (q.rw) begin
                  d.st = ST_TXDATA;
                  d.shift = q.mem[curAddr];
                  d.sdaLow = ~q.mem[curAddr][7];
               end else begin
                  d.st = ST_RXDATA;
                  d.sdaLow = 1'b0;
               end
            end
         end
         ST_RXDATA: begin
            if (sclRise) begin
               d.shift = {q.shift[6:0], sdaLvl};
               d.bitCnt = q.bitCnt + 4'h1;
            end else if (sclFall && q.bitCnt == `RTCS_BYTE_BITS) begin
               // bytes past the register's length are refused
               if (q.byteIdx < curLen) begin
                  d.mem[curAddr] = q.shift;
                  d.st = ST_ACKRX;
                  d.sdaLow = 1'b1;
               end else begin
                  d.st = ST_IGNORE;
               end
            end
         end
         ST_ACKRX: begin
            if (sclFall) begin
               d.sdaLow = 1'b0;
               d.st = ST_RXDATA;
               d.bitCnt = 4'h0;
               d.byteIdx = q.byteIdx + 3'h1;
            end
         end
         ST_TXDATA: begin
            if (sclFall) begin
               if (q.bitCnt == `RTCS_TX_LAST) begin
                  d.st = ST_TXACK;
                  d.sdaLow = 1'b0;
               end else begin
                  d.bitCnt = q.bitCnt + 4'h1;
                  d.sdaLow = ~q.shift[6];
                  d.shift = {q.shift[6:0], 1'b0};
               end
            end
         end
         ST_TXACK: begin
            if (sclRise) begin
               d.ackSeen = ~sdaLvl;
            end else if (sclFall) begin
               // a released line here ends the read, which is what recovery relies on
               if (q.ackSeen && ({1'b0, q.byteIdx} + 4'h1) < {1'b0, curLen}) begin
                  d.st = ST_TXDATA;
                  d.byteIdx = q.byteIdx + 3'h1;
                  d.bitCnt = 4'h0;
                  d.shift = nb;
                  d.sdaLow = ~nb[7];
               end else begin
                  d.st = ST_IGNORE;
               end
            end
         end
      endcase
      // the line conditions are blind while the data line is held low
      if (stopSeen && !q.sdaLow) begin
         d.st = ST_IDLE;
      end
      if (startSeen && !q.sdaLow && q.enable) begin
         d.st = ST_GETCMD;
         d.bitCnt = 4'h0;
      end
      // bus address phase; read data is taken from the updated copy
      d.apWrite = accept & hwrite;
      d.apRead = accept & ~hwrite;
      d.apAddr = (haddr[31:8] == 24'h0) ? haddr[7:0] : `RTCS_OFS_DATA - 8'h1;
      if (accept && !hwrite) begin
         d.hrdata = readMux(d, d.apAddr);
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         q <= '0;
         q.st <= ST_IDLE;
         q.enable <= `RTCS_CTRL_RESET;
      end else begin
         q <= d;
      end
   end

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = q.hrdata;
   assign sdaOut = 1'b0;
   assign sdaOe = q.sdaLow;

   ////////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clock); endclocking
   default disable iff (!resetn);

   sequence s_cmdByteDone;
      q.st == ST_GETCMD && sclFall && q.bitCnt == `RTCS_BYTE_BITS;
   endsequence

   property p_ackCode;
      s_cmdByteDone and q.shift[7:4] == DEV_CODE |=> q.sdaLow && q.st == ST_ACKCMD;
   endproperty
   a_ackCode: assert property (p_ackCode) else $error("own code not acknowledged");

   property p_foreignCode;
      s_cmdByteDone and q.shift[7:4] != DEV_CODE |=> !q.sdaLow && q.st == ST_IGNORE;
   endproperty
   a_foreignCode: assert property (p_foreignCode) else $error("foreign code acked");

   property p_writeMode;
      q.st == ST_ACKCMD && sclFall && !q.rw |=> q.st == ST_RXDATA && !q.sdaLow;
   endproperty
   a_writeMode: assert property (p_writeMode) else $error("write mode not entered");

   property p_stopIdle;
      stopSeen && !q.sdaLow |=> q.st == ST_IDLE;
   endproperty
   a_stopIdle: assert property (p_stopIdle) else $error("stop did not idle");

   property p_stopBlind;
      stopSeen && q.sdaLow |=> q.st == $past(q.st) && q.sdaLow;
   endproperty
   a_stopBlind: assert property (p_stopBlind) else $error("stop seen while low");

   property p_startBlind;
      startSeen && q.sdaLow |=> $stable(q.st) && $stable(q.bitCnt);
   endproperty
   a_startBlind: assert property (p_startBlind) else $error("start seen while low");

   property p_holdState;
      q.st != ST_IDLE && !startSeen && !stopSeen && !sclRise && !sclFall |=> $stable(q.st);
   endproperty
   a_holdState: assert property (p_holdState) else $error("state moved unprompted");

   property p_msbFirst;
      q.st == ST_TXDATA && sclFall && q.bitCnt < `RTCS_TX_LAST
         |=> q.sdaLow == !$past(q.shift[6]);
   endproperty
   a_msbFirst: assert property (p_msbFirst) else $error("read bit order wrong");

   property p_txRelease;
      q.st == ST_TXDATA && sclFall && q.bitCnt == `RTCS_TX_LAST
         |=> !q.sdaLow && q.st == ST_TXACK;
   endproperty
   a_txRelease: assert property (p_txRelease) else $error("line kept after byte");

   property p_statusSel;
      q.st == ST_RXDATA && sclFall && q.bitCnt == `RTCS_BYTE_BITS && q.cmd[2:1] == 2'h0
         && q.byteIdx == 3'h0
         |=> q.mem[$past(q.cmd[0])] == $past(q.shift);
   endproperty
   a_statusSel: assert property (p_statusSel) else $error("status select wrong");

   property p_intLen;
      q.st == ST_RXDATA && sclFall && q.bitCnt == `RTCS_BYTE_BITS && q.cmd[2:1] == 2'h2
         && q.byteIdx == 3'h1
         |=> q.sdaLow == $past(q.mem[`RTCS_BASE_STATUS2][q.cmd[0] ? 1 : 5]);
   endproperty
   a_intLen: assert property (p_intLen) else $error("interrupt length wrong");
endmodule

//--- rtl/rtcs_defines.svh
`ifndef RTCS_DEFINES_SVH
`define RTCS_DEFINES_SVH

// register offsets on the bus
`define RTCS_OFS_CTRL 8'h00
`define RTCS_OFS_STATUS 8'h04
`define RTCS_OFS_DATA 8'h40
`define RTCS_MEM_BYTES 20
`define RTCS_MEM_COUNT 6'h14

// control fields and reset values
`define RTCS_CTRL_EN_BIT 0
`define RTCS_CTRL_RESET 1'b1
`define RTCS_DEV_CODE_RESET 4'h6

// status fields
`define RTCS_STAT_STATE_LSB 0
`define RTCS_STAT_LOW_BIT 3
`define RTCS_STAT_CMD_LSB 4
`define RTCS_STAT_RW_BIT 7
`define RTCS_STAT_IDX_LSB 8
`define RTCS_STAT_BUSY_BIT 11

// commands carried in the first byte
`define RTCS_CMD_STATUS1 3'h0
`define RTCS_CMD_STATUS2 3'h1
`define RTCS_CMD_RT1 3'h2
`define RTCS_CMD_RT2 3'h3
`define RTCS_CMD_INTA 3'h4
`define RTCS_CMD_INTB 3'h5
`define RTCS_CMD_CORR 3'h6
`define RTCS_CMD_FREE 3'h7

// byte layout of the register contents
`define RTCS_BASE_STATUS 5'h00
`define RTCS_BASE_STATUS2 5'h01
`define RTCS_BASE_INTA 5'h02
`define RTCS_BASE_INTB 5'h05
`define RTCS_BASE_RT1 5'h08
`define RTCS_BASE_RT2 5'h0F
`define RTCS_BASE_CORR 5'h12
`define RTCS_BASE_FREE 5'h13

// transfer lengths in bytes
`define RTCS_LEN_RT1 3'h7
`define RTCS_LEN_RT2 3'h3
`define RTCS_LEN_ALARM 3'h3
`define RTCS_LEN_ONE 3'h1

// second status register: alarm mode for each interrupt pin
`define RTCS_S2_INTA_ALARM_BIT 5
`define RTCS_S2_INTB_ALARM_BIT 1

// bit counts
`define RTCS_BYTE_BITS 4'h8
`define RTCS_TX_LAST 4'h7

`endif

//--- rtl/rtcs_pkg.sv
package rtcs_pkg;
`include "rtcs_defines.svh"

   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_GETCMD = 3'h1,
      ST_ACKCMD = 3'h3,
      ST_RXDATA = 3'h2,
      ST_ACKRX = 3'h6,
      ST_TXDATA = 3'h7,
      ST_TXACK = 3'h5,
      ST_IGNORE = 3'h4
   } rtcs_state_type;

   typedef struct packed {
      rtcs_state_type st;
      logic [3:0] bitCnt;
      logic [7:0] shift;
      logic [2:0] cmd;
      logic rw;
      logic [2:0] byteIdx;
      logic sdaLow;
      logic ackSeen;
      logic [`RTCS_MEM_BYTES-1:0][7:0] mem;
      logic enable;
      logic apWrite;
      logic apRead;
      logic [7:0] apAddr;
      logic [31:0] hrdata;
   } rtcs_core_type;

   typedef struct packed {
      logic [1:0] s1;
      logic [1:0] s2;
      logic [1:0] s3;
   } rtcs_sync_type;

endpackage

//--- rtl/rtcs_pin_sync.sv
`timescale 1ns/10ps
module rtcs_pin_sync (
   // system
   input wire logic clock,
   input wire logic resetn,
   // pins
   input wire logic sclPin,
   input wire logic sdaPin,
   // synchronised view
   output logic sclHigh,
   output logic sdaLvl,
   output logic sclRise,
   output logic sclFall,
   output logic sdaRise,
   output logic sdaFall
);
   import rtcs_pkg::*;

   rtcs_sync_type q;
   rtcs_sync_type d;

   always_comb begin
      d = q;
      d.s1 = {sclPin, sdaPin};
      d.s2 = q.s1;
      d.s3 = q.s2;
   end

   // idle bus is high, so reset to high to avoid a false start
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         q <= '{s1: 2'h3, s2: 2'h3, s3: 2'h3};
      end else begin
         q <= d;
      end
   end

   // only s2 and s3 are looked at; s1 feeds s2 alone
   assign sclHigh = q.s2[1] & q.s3[1];
   assign sdaLvl = q.s2[0];
   assign sclRise = q.s2[1] & ~q.s3[1];
   assign sclFall = ~q.s2[1] & q.s3[1];
   assign sdaRise = q.s2[0] & ~q.s3[0];
   assign sdaFall = ~q.s2[0] & q.s3[0];
endmodule

//--- sim/rtcs_i2c_host.sv
`timescale 1ns/10ps
module rtcs_i2c_host (
   // bus lines, data is open drain with a pull-up
   output logic scl,
   output logic sdaLow,
   input wire logic sda
);
   // clock stands high between frames
   initial begin
      scl = 1'b1;
      sdaLow = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////////
   // one clock pulse, entered with scl just fallen; 64 ns per bit
   // data moves late in the low phase so the device's release has landed
   // lines change by non-blocking assignment, so one landing on a clock edge is seen after it
   task automatic bitx(input logic b, output logic r);
      #20 sdaLow <= ~b;
      #12 scl <= 1'b1;
      #32 r = sda;
      scl <= 1'b0;
   endtask
   task automatic start();
      sdaLow <= 1'b1;
      #32 scl <= 1'b0;
   endtask
   task automatic stop();
      logic r;
      #20 sdaLow <= 1'b1;
      #20 scl <= 1'b1;
      #20 sdaLow <= 1'b0;
      #32 r = sda;
   endtask
   task automatic sendByte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bitx(d[i], r);
      end
      bitx(1'b1, ack);
   endtask
   // zero acknowledge while more bytes are wanted, release on the last
   task automatic recvByte(input logic last, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bitx(1'b1, d[i]);
      end
      bitx(last, r);
   endtask
   // recovery clocking with data released; run after start, then stop
   task automatic pulses(input int n);
      logic r;
      repeat (n) bitx(1'b1, r);
   endtask
endmodule

//--- sim/tb_top.sv
`timescale 1ns/10ps
module tb_top;
   import rtcs_pkg::*;
   logic clock = 1'b0;
   logic resetn = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   wire logic hreadyout;
   wire logic hresp;
   wire logic [31:0] hrdata;
   wire logic sdaOut;
   wire logic sdaOe;
   wire logic scl;
   wire logic hostLow;
   wire logic sda = !(hostLow || (sdaOe && !sdaOut));
   int badCount = 0;
   int checksDone = 0;
   int cycles = 0;
   logic [31:0] rd;
   logic a;
   logic [7:0] b;
   always #2.5 clock = ~clock;
   rtcs_serial_port dut (.clock(clock), .resetn(resetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .sclPin(scl), .sdaPin(sda),
      .sdaOut(sdaOut), .sdaOe(sdaOe));
   rtcs_i2c_host host (.scl(scl), .sdaLow(hostLow), .sda(sda));
   ////////////////////////////////////////////////////////////////////////////
   task automatic finishTest();
      $display("checks %0d mismatches %0d", checksDone, badCount);
      if (badCount == 0 && checksDone > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checksDone++;
      if (seen !== exp) begin
         badCount++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // a hang costs far more than the whole run needs
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         badCount++;
         finishTest();
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic ahbCycle(input logic [31:0] ad, input logic wr, input logic [31:0] wd,
      output logic [31:0] r);
      @(posedge clock);
      hsel <= 1'b1;
      haddr <= ad;
      hwrite <= wr;
      htrans <= 2'h2;
      do @(posedge clock); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= wd;
      do @(posedge clock); while (hreadyout !== 1'b1);
      r = hrdata;
      check(32'(hresp), 32'h0);
   endtask
   task automatic ahbWrite(input logic [31:0] ad, input logic [31:0] wd);
      logic [31:0] r;
      ahbCycle(ad, 1'b1, wd, r);
   endtask
   task automatic ahbRead(input logic [31:0] ad, output logic [31:0] r);
      ahbCycle(ad, 1'b0, 32'h0, r);
   endtask
   task automatic hdr(input logic [2:0] c, input logic rw, input logic exp);
      logic ak;
      host.start();
      host.sendByte({`RTCS_DEV_CODE_RESET, c, rw}, ak);
      check(32'(ak), 32'(exp));
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // power-on quiet time is not modelled; the core has no detector
   initial begin
      repeat (3) @(posedge clock);
      resetn <= 1'b1;
      ahbRead(32'h00, rd);
      check(rd, 32'h1);
      ahbRead(32'h04, rd);
      check(rd & 32'hF, 32'h0);
      ahbWrite(32'h100, 32'hFF);
      ahbRead(32'h100, rd);
      check(rd, 32'h0);
      $display("test reset and map done");
      // status2 = alarm on both pins, never frequency output beside alarm
      hdr(`RTCS_CMD_STATUS1, 1'b0, 1'b0);
      host.sendByte(8'hA5, a);
      check(32'(a), 32'h0);
      host.stop();
      hdr(`RTCS_CMD_STATUS2, 1'b0, 1'b0);
      host.sendByte(8'h22, a);
      host.stop();
      ahbRead(32'h40, rd);
      check(rd, 32'hA5);
      ahbRead(32'h44, rd);
      check(rd, 32'h22);
      hdr(`RTCS_CMD_STATUS1, 1'b1, 1'b0);
      host.recvByte(1'b1, b);
      host.stop();
      check(32'(b), 32'hA5);
      $display("test status access done");
      for (int r = 0; r < 2; r++) begin
         hdr(3'(`RTCS_CMD_INTA + r), 1'b0, 1'b0);
         for (int k = 0; k < 4; k++) begin
            host.sendByte(8'(8'h31 + 4 * r + k), a);
            check(32'(a), 32'(k == 3));
         end
         host.stop();
         ahbRead(32'(32'h48 + 12 * r), rd);
         check(rd, 32'(32'h31 + 4 * r));
         hdr(3'(`RTCS_CMD_INTA + r), 1'b1, 1'b0);
         for (int k = 0; k < 3; k++) begin
            host.recvByte(k == 2, b);
            check(32'(b), 32'(32'h31 + 4 * r + k));
         end
         host.stop();
      end
      ahbWrite(32'h44, 32'h0);
      hdr(`RTCS_CMD_INTA, 1'b0, 1'b0);
      host.sendByte(8'h5A, a);
      check(32'(a), 32'h0);
      host.sendByte(8'h5B, a);
      check(32'(a), 32'h1);
      host.stop();
      ahbRead(32'h48, rd);
      check(rd, 32'h5A);
      ahbRead(32'h4C, rd);
      check(rd, 32'h32);
      $display("test interrupt registers done");
      host.start();
      host.sendByte(8'h30, a);
      check(32'(a), 32'h1);
      host.sendByte(8'h00, a);
      check(32'(a), 32'h1);
      host.stop();
      ahbRead(32'h40, rd);
      check(rd, 32'hA5);
      ahbWrite(32'h00, 32'h0);
      hdr(`RTCS_CMD_STATUS1, 1'b0, 1'b1);
      host.stop();
      ahbWrite(32'h00, 32'h1);
      $display("test refusals done");
      // abandon a read while the device drives zeros, then recover
      hdr(`RTCS_CMD_RT1, 1'b1, 1'b0);
      host.recvByte(1'b0, b);
      check(32'(b), 32'h0);
      host.pulses(3);
      host.stop();
      ahbRead(32'h04, rd);
      check(rd, 32'h9AF);
      host.start();
      host.pulses(63);
      host.stop();
      ahbRead(32'h04, rd);
      check(rd & 32'hF, 32'h0);
      check(32'(sda), 32'h1);
      check(32'(sdaOut), 32'h0);
      hdr(`RTCS_CMD_STATUS1, 1'b0, 1'b0);
      host.sendByte(8'h0F, a);
      host.stop();
      ahbRead(32'h40, rd);
      check(rd, 32'h0F);
      $display("test recovery done");
      // the remaining commands, each in its own bytes with its own length
      ahbWrite(32'h90, 32'hFF);
      ahbRead(32'h90, rd);
      check(rd, 32'h0);
      for (int c = 6; c < 8; c++) begin
         hdr(3'(c), 1'b0, 1'b0);
         host.sendByte(8'(8'hC0 + c), a);
         check(32'(a), 32'h0);
         host.sendByte(8'h00, a);
         check(32'(a), 32'h1);
         host.stop();
         ahbRead(32'(32'h70 + 4 * c), rd);
         check(rd, 32'(32'hC0 + c));
      end
      hdr(`RTCS_CMD_RT2, 1'b0, 1'b0);
      for (int k = 0; k < 4; k++) begin
         host.sendByte(8'(8'h70 + k), a);
         check(32'(a), 32'(k == 3));
      end
      host.stop();
      hdr(`RTCS_CMD_RT2, 1'b1, 1'b0);
      for (int k = 0; k < 3; k++) begin
         host.recvByte(k == 2, b);
         check(32'(b), 32'(8'h70 + k));
      end
      host.stop();
      ahbRead(32'h7C, rd);
      check(rd, 32'h70);
      ahbRead(32'h84, rd);
      check(rd, 32'h72);
      $display("test remaining commands done");
      // a reset in mid-run clears the bytes and the read data
      resetn <= 1'b0;
      repeat (3) @(posedge clock);
      check(hrdata, 32'h0);
      resetn <= 1'b1;
      ahbRead(32'h7C, rd);
      check(rd, 32'h0);
      ahbRead(32'h00, rd);
      check(rd, 32'h1);
      $display("test reset in mid-run done");
      finishTest();
   end
endmodule
